// ---- eec_pkg.sv ----
/*
  eec_pkg: constants, state and role types of the two-wire eeprom client front end.
  assumes nothing of its surroundings; imported whole by every module of the block.
*/
`default_nettype none
package eec_pkg;
  // ***************************************************************
  // widths and fixed layout
  // ***************************************************************
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int CS_W = 3;
  localparam int PIN_W = 4;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [3:0] BIT_FIRST_TX = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 14'h3fff;
  localparam logic [1:0] BUS_RST = 2'h3;
  localparam logic [PIN_W-1:0] PIN_RST = 4'h0;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_HACK = 6'h10,
    ST_SKIP = 6'h20
  } eec_state_t;

  typedef enum logic [1:0] {
    ROLE_CTRL = 2'h0,
    ROLE_ADRH = 2'h1,
    ROLE_ADRL = 2'h2,
    ROLE_DATA = 2'h3
  } eec_role_t;
endpackage
`default_nettype wire

// ---- eec_sync.sv ----
/*
  eec_sync: three-stage synchroniser with agreement filter for pin inputs.
  assumes inputs are asynchronous to clk; output follows only once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module eec_sync
  import eec_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins in, filtered level out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] filt_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] filt_nxt;

  always_comb
  begin
    // a bit moves only when it has been seen twice, which swallows one-sample spikes
    filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      filt_r <= RST_VAL;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end
endmodule // eec_sync
`default_nettype wire

// ---- eec_page_buf.sv ----
/*
  eec_page_buf: one page of write data, one write port, one registered read port.
  assumes the array side reads it only while no write transfer is filling it.
*/
`timescale 1ns/1ns
`default_nettype none
module eec_page_buf
  import eec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic we,
  input wire logic [PAGE_W-1:0] widx,
  input wire logic [7:0] wdata,
  // drain side
  input wire logic [PAGE_W-1:0] ridx,
  output logic [7:0] rdata_r
);
  logic [7:0] mem [PAGE_BYTES];
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = mem[ridx];
  end

  // storage carries no reset; only the byte mask says what is valid
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[widx] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end
endmodule // eec_page_buf
`default_nettype wire

// ---- eec_client.sv ----
/*
  eec_client: two-wire bus client front end of a serial eeprom.
  assumes the array side supplies read data for rd_addr within a few clocks, raises write_busy
  for the whole programming cycle after commit, and drains the page buffer by buf_ridx.
*/
`timescale 1ns/1ns
`default_nettype none
module eec_client
  import eec_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE_CODE = 4'h5 // arbitrary value, set per product
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // strap pins
  input wire logic [CS_W-1:0] cs_pins,
  input wire logic write_protect_input,
  // array read side
  input wire logic [7:0] rd_data,
  output logic [ADDR_W-1:0] rd_addr,
  // array write side
  input wire logic write_busy,
  output logic commit,
  output logic [ADDR_W-PAGE_W-1:0] commit_page,
  output logic [PAGE_BYTES-1:0] wr_mask,
  input wire logic [PAGE_W-1:0] buf_ridx,
  output logic [7:0] buf_rdata
);
  // ***************************************************************
  // input conditioning and bus events
  // ***************************************************************
  logic [1:0] bus_f;
  logic [PIN_W-1:0] pin_f;
  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic [CS_W-1:0] cs_f;
  logic scl_p_r;
  logic sda_p_r;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  eec_sync #(.W(2), .RST_VAL(BUS_RST)) u_bus_sync
  (
    .clk(clk),
    .rstn(rstn),
    .pin_in({scl_i, sda_i}),
    .filt_r(bus_f)
  );

  eec_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync
  (
    .clk(clk),
    .rstn(rstn),
    .pin_in({write_protect_input, cs_pins}),
    .filt_r(pin_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];
  assign wp_f = pin_f[PIN_W-1];
  assign cs_f = pin_f[CS_W-1:0];

  assign start_ev = scl_f && scl_p_r && sda_p_r && !sda_f;
  assign stop_ev = scl_f && scl_p_r && !sda_p_r && sda_f;
  assign scl_rise = scl_f && !scl_p_r;
  assign scl_fall = !scl_f && scl_p_r;

  // ***************************************************************
  // protocol state
  // ***************************************************************
  eec_state_t state_r, state_nxt;
  eec_role_t role_r, role_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] txb_r, txb_nxt;
  logic [7:0] byte_in;
  logic ack_ok_r, ack_ok_nxt;
  logic rd_r, rd_nxt;
  logic oe_r, oe_nxt;
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [PAGE_BYTES-1:0] mask_r, mask_nxt;
  logic got_r, got_nxt;
  logic commit_r, commit_nxt;
  logic [ADDR_W-PAGE_W-1:0] page_r, page_nxt;
  logic buf_we;

  always_comb
  begin
    state_nxt = state_r;
    role_nxt = role_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    txb_nxt = txb_r;
    ack_ok_nxt = ack_ok_r;
    rd_nxt = rd_r;
    oe_nxt = oe_r;
    ptr_nxt = ptr_r;
    mask_nxt = mask_r;
    got_nxt = got_r;
    commit_nxt = 1'b0;
    page_nxt = page_r;
    buf_we = 1'b0;
    byte_in = {shift_r[6:0], sda_f};
    if (start_ev)
    begin
      // a repeated start also ends a write that never saw its stop
      state_nxt = ST_RX;
      role_nxt = ROLE_CTRL;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      got_nxt = 1'b0;
    end
    else if (stop_ev)
    begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
      if (role_r == ROLE_DATA && got_r && !wp_f)
      begin
        commit_nxt = 1'b1;
        page_nxt = ptr_r[ADDR_W-1:PAGE_W];
      end
    end
    else
    begin
      case (state_r)
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_nxt = byte_in;
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == BIT_LAST)
            begin
              ack_ok_nxt = 1'b1;
              case (role_r)
                ROLE_CTRL:
                begin
                  ack_ok_nxt = (byte_in[7:4] == DEV_TYPE_CODE) && (byte_in[3:1] == cs_f) && !write_busy;
                  rd_nxt = byte_in[0];
                end
                ROLE_ADRH:
                begin
                  ptr_nxt[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
                end
                ROLE_ADRL:
                begin
                  ptr_nxt[7:0] = byte_in;
                end
                ROLE_DATA:
                begin
                  buf_we = 1'b1;
                  mask_nxt[ptr_r[PAGE_W-1:0]] = 1'b1;
                  ptr_nxt[PAGE_W-1:0] = ptr_r[PAGE_W-1:0] + 6'h01;
                  got_nxt = 1'b1;
                end
                default:
                begin
                  ack_ok_nxt = 1'b0;
                end
              endcase
            end
          end
          else if (scl_fall && cnt_r == BIT_DONE)
          begin
            cnt_nxt = 4'h0;
            state_nxt = ack_ok_r ? ST_ACK : ST_SKIP;
            oe_nxt = ack_ok_r;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            state_nxt = ST_RX;
            if (role_r == ROLE_CTRL && rd_r)
            begin
              state_nxt = ST_TX;
              oe_nxt = !rd_data[7];
              txb_nxt = {rd_data[6:0], 1'b0};
              cnt_nxt = BIT_FIRST_TX;
            end
            else if (role_r == ROLE_CTRL)
            begin
              role_nxt = ROLE_ADRH;
              mask_nxt = '0;
              got_nxt = 1'b0;
            end
            else if (role_r == ROLE_ADRH)
            begin
              role_nxt = ROLE_ADRL;
            end
            else
            begin
              role_nxt = ROLE_DATA;
            end
          end
        end
        ST_TX:
        begin
          // the pin moves only after a clock fall, never while clock is high
          if (scl_fall)
          begin
            if (cnt_r == BIT_DONE)
            begin
              state_nxt = ST_HACK;
              oe_nxt = 1'b0;
            end
            else
            begin
              oe_nxt = !txb_r[7];
              txb_nxt = {txb_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_HACK:
        begin
          if (scl_rise)
          begin
            ack_ok_nxt = !sda_f;
            ptr_nxt = ptr_r + 14'h0001;
          end
          else if (scl_fall)
          begin
            state_nxt = ack_ok_r ? ST_TX : ST_SKIP;
            oe_nxt = ack_ok_r && !rd_data[7];
            txb_nxt = {rd_data[6:0], 1'b0};
            cnt_nxt = BIT_FIRST_TX;
          end
        end
        ST_IDLE, ST_SKIP:
        begin
          oe_nxt = 1'b0;
        end
        default:
        begin
          state_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      state_r <= ST_IDLE;
      role_r <= ROLE_CTRL;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      txb_r <= 8'h00;
      ack_ok_r <= 1'b0;
      rd_r <= 1'b0;
      oe_r <= 1'b0;
      ptr_r <= ADDR_RST;
      mask_r <= '0;
      got_r <= 1'b0;
      commit_r <= 1'b0;
      page_r <= '0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_p_r <= scl_f;
      sda_p_r <= sda_f;
      state_r <= state_nxt;
      role_r <= role_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      txb_r <= txb_nxt;
      ack_ok_r <= ack_ok_nxt;
      rd_r <= rd_nxt;
      oe_r <= oe_nxt;
      ptr_r <= ptr_nxt;
      mask_r <= mask_nxt;
      got_r <= got_nxt;
      commit_r <= commit_nxt;
      page_r <= page_nxt;
      sda_o <= 1'b0;
    end
  end

  // ***************************************************************
  // page buffer and outputs
  // ***************************************************************
  eec_page_buf u_page_buf
  (
    .clk(clk),
    .rstn(rstn),
    .we(buf_we),
    .widx(ptr_r[PAGE_W-1:0]),
    .wdata(byte_in),
    .ridx(buf_ridx),
    .rdata_r(buf_rdata)
  );

  assign sda_oe = oe_r;
  assign rd_addr = ptr_r;
  assign commit = commit_r;
  assign commit_page = page_r;
  assign wr_mask = mask_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  start_arm_a: assert property (start_ev |=> state_r == ST_RX && role_r == ROLE_CTRL && cnt_r == 4'h0)
    else $error("start did not re-arm the control byte");
  stop_rel_a: assert property (stop_ev |=> state_r == ST_IDLE && !sda_oe)
    else $error("stop did not release the bus");
  bit_take_a: assert property (state_r == ST_RX && scl_rise && !start_ev && !stop_ev |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("bit not counted on clock rise");
  busy_noack_a: assert property (state_r == ST_RX && role_r == ROLE_CTRL && write_busy && scl_rise && cnt_r == BIT_LAST && !start_ev && !stop_ev ##1 (!start_ev && !stop_ev)[*1] |-> !ack_ok_r)
    else $error("control byte accepted while busy");
  ack_hold_a: assert property (state_r == ST_ACK |-> sda_oe)
    else $error("acknowledge not held low");
  skip_rel_a: assert property (state_r == ST_SKIP |-> !sda_oe ##1 (state_r != ST_SKIP || !sda_oe))
    else $error("data driven after mismatch");
  wp_block_a: assert property (commit_r |-> !$past(wp_f) && $past(stop_ev))
    else $error("commit despite write protect");
  page_wrap_a: assert property (buf_we && !start_ev && !stop_ev |=> ptr_r[ADDR_W-1:PAGE_W] == $past(ptr_r[ADDR_W-1:PAGE_W]) && ptr_r[PAGE_W-1:0] == $past(ptr_r[PAGE_W-1:0]) + 6'h01)
    else $error("page pointer left its page");
  seq_wrap_a: assert property (state_r == ST_HACK && scl_rise && !sda_f && ptr_r == ADDR_TOP && !start_ev && !stop_ev |=> ptr_r == ADDR_RST)
    else $error("read pointer did not wrap");
  tx_stable_a: assert property (state_r == ST_TX && scl_f && scl_p_r |=> $stable(sda_oe) || $past(start_ev) || $past(stop_ev))
    else $error("data changed while clock high");

  ack_seen_c: cover property (state_r == ST_ACK && role_r == ROLE_CTRL);
  read_done_c: cover property (state_r == ST_HACK && scl_rise && sda_f);
  commit_c: cover property (commit_r);
  wrap_c: cover property (state_r == ST_HACK && ptr_r == ADDR_TOP && scl_rise && !sda_f);
endmodule // eec_client
`default_nettype wire

// ---- eec_host_model.sv ----
/*
  eec_host_model: behavioural two-wire bus host driving the bus clock and its share of the data wire.
  assumes the bench resolves the data wire with a pull-up; all changes land on falling clk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module eec_host_model
(
  // bench clock
  input wire logic clk,
  // bus
  output logic scl,
  output logic host_oe,
  input wire logic sda
);
  // ***************************************************************
  // bus cycles
  // ***************************************************************
  int tog = 0;
  initial
  begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // from idle or after an acknowledge; the long wait lets the client let go first
  task automatic start();
    host_oe = 1'b0;
    wt(6);
    scl = 1'b1;
    wt(3);
    host_oe = 1'b1;
    wt(3);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(3);
    host_oe = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(3);
    host_oe = 1'b0;
    wt(6);
  endtask
  // low phase 6 or 7 clocks, high 6: averages one 125 ns bit
  task automatic bit_io(input logic b, output logic s);
    wt(3);
    host_oe = ~b;
    wt(3 + tog);
    tog = 1 - tog;
    scl = 1'b1;
    wt(5);
    s = sda; // sampled late in the high phase, away from the client's turn delay
    wt(1);
    scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~ack, s);
  endtask
endmodule // eec_host_model
`default_nettype wire

// ---- testbench.sv ----
/*
  testbench: self-checking bench of eec_client against the host model and a simple array model.
  assumes eec_host_model alongside; array answers reads combinationally and is busy after commit.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import eec_pkg::*;
;
  // ***************************************************************
  // signals and models
  // ***************************************************************
  localparam logic [3:0] TYPE = 4'h9; // arbitrary type code
  logic clk = 1'b0;
  logic rstn, scl, host_oe, sda, sda_o, sda_oe, wp, write_busy, commit, ack;
  logic [2:0] cs;
  logic [13:0] rd_addr;
  logic [7:0] rd_data, commit_page, buf_rdata, d;
  logic [63:0] wr_mask, exp_mask;
  logic [5:0] buf_ridx;
  logic [7:0] exp_buf [64];
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int busy_cnt = 0;
  int n_commit = 0;
  always #5 clk = ~clk;
  assign sda = ~(host_oe | (sda_oe & ~sda_o));
  assign rd_data = exp_rd(rd_addr);
  assign write_busy = busy_cnt != 0;
  function automatic logic [7:0] exp_rd(input logic [13:0] a);
    return a[7:0] ^ {a[13:8], 2'h2};
  endfunction
  always @(posedge clk)
  begin
    cyc++;
    if (commit === 1'b1)
    begin
      busy_cnt <= 400;
      n_commit++;
    end
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  eec_client #(.DEV_TYPE_CODE(TYPE)) eec_client_inst (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cs_pins(cs), .write_protect_input(wp), .rd_data(rd_data),
    .rd_addr(rd_addr), .write_busy(write_busy), .commit(commit), .commit_page(commit_page),
    .wr_mask(wr_mask), .buf_ridx(buf_ridx), .buf_rdata(buf_rdata));
  eec_host_model eec_host_model_inst (.clk(clk), .scl(scl), .host_oe(host_oe), .sda(sda));
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task automatic snd(input logic [7:0] b, input logic exp_ack);
    eec_host_model_inst.send_byte(b, ack);
    chk(64'(ack), 64'(exp_ack), "acknowledge");
  endtask
  task automatic rcv(input logic a, input logic [7:0] exp);
    eec_host_model_inst.recv_byte(a, d);
    chk(64'(d), 64'(exp), "read byte");
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 600 && write_busy; i++)
      eec_host_model_inst.wt(1);
  endtask
  // wp is flipped right after Stop: the cycle already decided must not change
  task automatic page_wr(input logic [13:0] a, input int n, input logic prot);
    int c0;
    int k;
    c0 = n_commit;
    wp = prot;
    exp_mask = '0;
    eec_host_model_inst.start();
    snd({TYPE, cs, 1'b0}, 1'b1);
    snd({2'($urandom), a[13:8]}, 1'b1);
    snd(a[7:0], 1'b1);
    for (int i = 0; i < n; i++)
    begin
      k = (int'(a[5:0]) + i) % 64;
      d = 8'($urandom);
      exp_buf[k] = d;
      exp_mask[k] = 1'b1;
      snd(d, 1'b1);
    end
    eec_host_model_inst.stop();
    wp = ~prot;
    eec_host_model_inst.wt(30);
    chk(64'(n_commit - c0), 64'(prot ? 0 : 1), "commit count");
    if (!prot)
    begin
      chk(64'(commit_page), 64'(a[13:6]), "commit page");
      chk(wr_mask, exp_mask, "write mask");
      for (int i = 0; i < 64; i++)
      begin
        buf_ridx = 6'(i);
        eec_host_model_inst.wt(2);
        if (exp_mask[i])
          chk(64'(buf_rdata), 64'(exp_buf[i]), "page byte");
      end
    end
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    rstn = 1'b0;
    cs = 3'h0;
    wp = 1'b0;
    buf_ridx = 6'h00;
    void'($urandom(32'hcaff359e));
    cs = 3'($urandom);
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    eec_host_model_inst.wt(10);
    page_wr(14'($urandom), 3, 1'b0);
    eec_host_model_inst.start();
    snd({TYPE, cs, 1'b0}, 1'b0);
    eec_host_model_inst.stop();
    wait_idle();
    page_wr({8'($urandom), 6'h3e}, 67, 1'b0);
    wait_idle();
    page_wr(14'($urandom), 2, 1'b1);
    eec_host_model_inst.start();
    snd({TYPE, cs ^ 3'h4, 1'b0}, 1'b0);
    snd(8'h00, 1'b0);
    eec_host_model_inst.stop();
    eec_host_model_inst.start();
    snd({~TYPE, cs, 1'b1}, 1'b0);
    eec_host_model_inst.stop();
    eec_host_model_inst.start();
    snd({TYPE, cs, 1'b0}, 1'b1);
    snd(8'hff, 1'b1);
    snd(8'hfe, 1'b1);
    eec_host_model_inst.start();
    snd({TYPE, cs, 1'b1}, 1'b1);
    rcv(1'b1, exp_rd(14'h3ffe));
    rcv(1'b1, exp_rd(14'h3fff));
    rcv(1'b0, exp_rd(14'h0000));
    chk(64'(sda_oe), 64'(1'b0), "released after nack");
    eec_host_model_inst.stop();
    chk(64'(rd_addr), 64'(14'h0001), "pointer");
    eec_host_model_inst.start();
    snd({TYPE, cs, 1'b1}, 1'b1);
    rcv(1'b0, exp_rd(14'h0001));
    eec_host_model_inst.stop();
    // variant without the two lower straps: host sends zeros there
    cs = {cs[2], 2'h0};
    eec_host_model_inst.wt(10);
    eec_host_model_inst.start();
    snd({TYPE, cs, 1'b1}, 1'b1);
    rcv(1'b0, exp_rd(14'h0002));
    eec_host_model_inst.stop();
    test_done();
  end
endmodule // testbench
`default_nettype wire
